// ---- rtl/card_host_ctrl.sv ----
// Purpose: Host-side controller driving a removable card's parallel port
// Assumes: One clock, card detect and handshake pins sampled through pin_sync3
// Notes: Handles selects, byte lanes, detect and master/slave strap
// Function
// - Address bit zero steers bytes onto low lane
// - Task file reached under first select
// - Second select reaches control block registers
// - Data line zero is even byte LSB
// - Data line eight is odd byte LSB
// - Task file accesses are low-lane bytes
// - IDE data transfers use all sixteen lines
// - Activity line shows disk active, slave present
// - Only low three address bits in IDE
// - Diagnostic line passes the diagnostic result
`timescale 1ns/1ns
`default_nettype none
module card_host_ctrl
  import card_host_pkg::*;
#(
  parameter int ACCESS_CYCLES = ACCESS_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire card_mode_e mode,
  input wire logic want_slave,
  input wire logic req_valid,
  output logic req_ready,
  input wire host_req_s req,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic card_present,
  output logic disk_active,
  output logic diag_passed,
  output card_sel_s sel,
  output logic master_slave_strap_n_o,
  output logic master_slave_strap_n_oe,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic insert_detect_a_n,
  input wire logic insert_detect_b_n,
  input wire logic activity_slave_present_n_i,
  input wire logic pass_diagnostic_n_i
);

  typedef enum logic [1:0] {st_idle, st_strobe, st_done} state_e;

  // Sequencer state, strobe counter and the request being served
  state_e state_q;
  logic [7:0] cnt_q;
  host_req_s cur_q;
  logic [DATA_W-1:0] rdata_q;
  // Filtered card pins, still active low
  logic [1:0] detect_n;
  logic [1:0] hs_n;
  logic seated;
  logic is_ide;
  // Strobe phase helpers shared by the pin and capture processes
  logic last_strobe;
  logic drive_wr;

  assign is_ide = (mode == ide_compatible_operation);

  // Final strobe cycle: read data is sampled while the card still drives it
  assign last_strobe = (state_q == st_strobe) && (cnt_q <= 8'h01);

  // Write data outlives the strobe by one cycle so the card's trailing-edge
  // latch never sees the bus change in the same instant as its write strobe
  assign drive_wr = cur_q.write && (state_q == st_strobe || state_q == st_done);

  // Card pins are asynchronous; filter through three stages
  // Both detects must read low through the filter before the card counts
  pin_sync3 #(.WIDTH(2), .RST_VAL(2'h3)) u_det (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in({insert_detect_b_n, insert_detect_a_n}),
    .level_q(detect_n)
  );

  // Handshake lines only carry meaning in IDE operation
  pin_sync3 #(.WIDTH(2), .RST_VAL(2'h3)) u_hs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in({pass_diagnostic_n_i, activity_slave_present_n_i}),
    .level_q(hs_n)
  );

  assign seated = (detect_n == 2'h0);
  assign card_present = seated;

  assign disk_active = is_ide && !hs_n[0];
  assign diag_passed = is_ide && !hs_n[1];

  // Open-drain strap: the host only ever grounds it; driving it high would
  // fight the card's pull-up for nothing
  // ground strap for master
  // release strap, card pull-up makes slave
  assign master_slave_strap_n_o = 1'b0;
  assign master_slave_strap_n_oe = !(is_ide && !want_slave);

  // Refuse new work while busy or with no card seated; a pulled card would
  // otherwise leave a strobe hanging on an empty socket
  assign req_ready = (state_q == st_idle) && seated;

  // Access sequencer; holds pins stable for the strobe time
  // Counts of zero or one both give a single strobe cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= st_idle;
      cnt_q <= 8'h00;
      cur_q <= '0;
    end else begin
      case (state_q)
        st_idle: begin
          if (req_valid && req_ready) begin
            cur_q <= req;
            cnt_q <= 8'(ACCESS_CYCLES);
            state_q <= st_strobe;
          end
        end
        st_strobe: begin
          if (cnt_q <= 8'h01) begin
            state_q <= st_done;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        st_done: state_q <= st_idle;
        default: state_q <= st_idle;
      endcase
    end
  end

  // Select and address pins from the latched request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sel <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ADDR_RST};
    end else if (state_q == st_strobe) begin
      sel.rd_n <= cur_q.write;
      sel.wr_n <= !cur_q.write;
      if (is_ide) begin
        sel.taskfile_select_n <= !(cur_q.kind != req_control);
        sel.control_block_select_n <= !(cur_q.kind == req_control);
        sel.addr <= {{(ADDR_W-IDE_REG_W){1'b0}}, cur_q.addr[IDE_REG_W-1:0]};
        // Card enables stay released; IDE uses the chip selects alone
        sel.card_enable_low_n <= 1'b1;
        sel.card_enable_high_n <= 1'b1;
      end else begin
        // same enables in both card modes
        // byte access: low enable plus A0
        // A0 picks even or odd byte
        sel.card_enable_low_n <= 1'b0;
        sel.card_enable_high_n <= (cur_q.kind != req_word);
        sel.addr <= cur_q.addr;
        sel.taskfile_select_n <= 1'b1;
        sel.control_block_select_n <= 1'b1;
      end
    end else begin
      // Idle: selects and strobes released, address parked at zero
      sel <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ADDR_RST};
    end
  end

  // Write data lanes; odd byte on a byte access still rides the low lane
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      data_o <= DATA_RST;
      data_oe <= 1'b1;
    end else if (drive_wr) begin
      // even byte LSB on line zero
      // odd byte LSB on line eight
      // task file on low lane only
      if (cur_q.kind == req_word && (is_ide || !cur_q.addr[0])) begin
        data_o <= cur_q.wdata;
      end else begin
        data_o <= {8'h00, cur_q.wdata[BYTE_W-1:0]};
      end
      data_oe <= 1'b0;
    end else begin
      data_o <= DATA_RST;
      data_oe <= 1'b1;
    end
  end

  // Capture read data on the last strobe cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= DATA_RST;
    end else if (last_strobe && !cur_q.write) begin
      if (cur_q.kind == req_word) begin
        rdata_q <= data_i;
      end else begin
        rdata_q <= {8'h00, data_i[EVEN_LSB +: BYTE_W]};
      end
    end
  end

  // Response flag lasts the one done cycle; read data stands until the
  // next read replaces it
  assign rsp_valid = (state_q == st_done);
  assign rsp_data = rdata_q;

endmodule
`default_nettype wire

// ---- rtl/card_host_pkg.sv ----
// Purpose: Shared constants and carriers for the card host port controller
// Assumes: 20 MHz system clock, one clock domain
// Notes: Pin-facing groups travel as packed structs
package card_host_pkg;

  // Operating modes of the card interface
  typedef enum logic [1:0] {
    memory_mapped_operation,
    io_mapped_operation,
    ide_compatible_operation
  } card_mode_e;

  // Bus widths and lane positions
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 11;
  localparam int EVEN_LSB = 0;
  localparam int ODD_LSB = 8;
  localparam int IDE_REG_W = 3;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // Strobe timing: one access is held on the pins for this long
  localparam int ACCESS_NS = 300;
  localparam int CLK_NS = 50;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;

  // Kinds of host request
  typedef enum logic [1:0] {
    req_byte,
    req_word,
    req_taskfile,
    req_control
  } req_kind_e;

  // Request from the host user side
  typedef struct packed {
    req_kind_e kind;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } host_req_s;

  // Select and address pins driven toward the card
  typedef struct packed {
    logic card_enable_low_n;
    logic card_enable_high_n;
    logic taskfile_select_n;
    logic control_block_select_n;
    logic rd_n;
    logic wr_n;
    logic [ADDR_W-1:0] addr;
  } card_sel_s;

endpackage

// ---- rtl/pin_sync3.sv ----
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Input is asynchronous to clk_sys
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync3
  import card_host_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per-bit agreement filter
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          level_q[i] <= RST_VAL[i];
        end else if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- tb/card_host_ctrl_properties.sv ----
// Purpose: Port checks on card_host_ctrl
// Assumes: One clock, rstn low resets
// Notes: Repeats allow for registered selects
`timescale 1ns/1ns
`default_nettype none
module card_host_ctrl_properties
  import card_host_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire card_mode_e mode,
  input wire logic want_slave,
  input wire card_sel_s sel,
  input wire logic master_slave_strap_n_oe,
  input wire logic data_oe,
  input wire logic diag_passed
);
  logic ide;
  logic stb;
  logic any_sel;
  // Strobe low marks an access on the pins
  assign ide = mode == ide_compatible_operation;
  assign stb = !(sel.rd_n && sel.wr_n);
  assign any_sel = !(sel.taskfile_select_n && sel.control_block_select_n);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_strap_master: assert property ((ide && !want_slave)[*4] |-> !master_slave_strap_n_oe)
    else $error("strap not driven");
  a_strap_slave: assert property ((ide && want_slave)[*4] |-> master_slave_strap_n_oe)
    else $error("strap not released");
  a_strap_outside_ide: assert property (!ide |-> master_slave_strap_n_oe)
    else $error("strap driven outside ide");
  a_low_enable: assert property (!ide && stb |-> !sel.card_enable_low_n)
    else $error("low enable missing");
  a_no_ide_select: assert property (!ide |-> !any_sel)
    else $error("ide select outside ide");
  a_one_select: assert property (ide && stb |->
    sel.taskfile_select_n ^ sel.control_block_select_n) else $error("select count");
  a_ide_addr_low: assert property (ide && stb |-> sel.addr[ADDR_W-1:IDE_REG_W] == '0)
    else $error("upper address set");
  a_no_drive_read: assert property (!sel.rd_n |-> data_oe)
    else $error("host drives on read");
  a_diag_ide_only: assert property ((!ide)[*2] |-> !diag_passed)
    else $error("diag outside ide");
endmodule
bind card_host_ctrl card_host_ctrl_properties i_props (.clk_sys, .rstn, .mode, .want_slave,
  .sel, .master_slave_strap_n_oe, .data_oe, .diag_passed);
`default_nettype wire

// ---- tb/card_host_select_and_byte_lanes_tb.sv ----
// Purpose: Self-checking bench for card_host_ctrl
// Assumes: Default access length, 50 ns clock
// Notes: Table rows, then diag, strap, detect, mid-run reset
`timescale 1ns/1ns
`default_nettype none
module card_host_select_and_byte_lanes_tb
  import card_host_pkg::*;
;
  typedef struct packed {
    card_mode_e m;
    req_kind_e k;
    logic w;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
  } row_s;
  localparam card_mode_e mem_m = memory_mapped_operation;
  localparam card_mode_e ide_m = ide_compatible_operation;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  card_mode_e mode = mem_m;
  logic want_slave = 1'b0;
  logic req_valid = 1'b0;
  host_req_s req = '0;
  logic diag_n = 1'b1;
  logic seated = 1'b1;
  logic act_n = 1'b1;
  logic req_ready, rsp_valid, card_present, disk_active, diag_passed, data_oe;
  logic strap_o, strap_oe, det_a, det_b, is_slave;
  logic [DATA_W-1:0] rsp_data, data_i, data_o;
  card_sel_s sel;
  int n_fail = 0;
  int check_count = 0;
  // Writes carry data, reads the expected answer
  row_s rows [10] = '{
    '{mem_m, req_word, 1'b1, 11'h002, 16'h1234}, '{mem_m, req_word, 1'b0, 11'h002, 16'h1234},
    '{mem_m, req_byte, 1'b0, 11'h002, 16'h0034},
    '{io_mapped_operation, req_byte, 1'b0, 11'h003, 16'h0012},
    '{ide_m, req_taskfile, 1'b1, 11'h005, 16'h5577}, '{ide_m, req_taskfile, 1'b0, 11'h005, 16'h0077},
    '{ide_m, req_word, 1'b1, 11'h006, 16'hBEEF}, '{ide_m, req_word, 1'b0, 11'h006, 16'hBEEF},
    '{ide_m, req_control, 1'b1, 11'h006, 16'h0042}, '{ide_m, req_control, 1'b0, 11'h006, 16'h0042}};
  always #25 clk_sys = ~clk_sys;
  card_host_ctrl i_dut (.clk_sys, .rstn, .mode, .want_slave, .req_valid, .req_ready, .req,
    .rsp_valid, .rsp_data, .card_present, .disk_active, .diag_passed, .sel,
    .master_slave_strap_n_o(strap_o), .master_slave_strap_n_oe(strap_oe), .data_i, .data_o,
    .data_oe, .insert_detect_a_n(det_a), .insert_detect_b_n(det_b),
    .activity_slave_present_n_i(act_n), .pass_diagnostic_n_i(diag_n));
  card_model i_card (.sel, .data_o, .data_oe, .strap_n_o(strap_o), .strap_n_oe(strap_oe),
    .seated, .data_i, .det_a_n(det_a), .det_b_n(det_b), .is_slave);
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded wait on a handshake flag
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    if (s !== 1'b1) n_fail++;
  endtask
  task automatic run(input row_s r);
    @(negedge clk_sys);
    mode = r.m;
    req = '{r.k, r.w, r.a, r.w ? r.d : 16'h0000};
    req_valid = 1'b1;
    wait_hi(req_ready);
    @(negedge clk_sys);
    req_valid = 1'b0;
    wait_hi(rsp_valid);
    if (!r.w) check(rsp_data, r.d);
  endtask
  // Watchdog well past the expected run
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    check(16'({sel.rd_n, sel.wr_n, data_oe, req_ready}), 16'h000E);
    rstn = 1'b1;
    foreach (rows[i]) run(rows[i]);
    diag_n = 1'b0;
    act_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(16'({disk_active, diag_passed}), 16'h0003);
    want_slave = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(16'(is_slave), 16'h0001);
    want_slave = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(16'(is_slave), 16'h0000);
    mode = mem_m;
    repeat (4) @(negedge clk_sys);
    check(16'({strap_oe, disk_active, diag_passed}), 16'h0004);
    seated = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(16'({card_present, req_ready}), 16'h0000);
    seated = 1'b1;
    repeat (8) @(negedge clk_sys);
    check(16'({card_present, req_ready}), 16'h0003);
    // Reset in mid-write: pins let go at once, other words keep their data
    req = '{req_word, 1'b1, 11'h004, 16'hA5A5};
    req_valid = 1'b1;
    repeat (3) @(negedge clk_sys);
    req_valid = 1'b0;
    rstn = 1'b0;
    @(negedge clk_sys);
    check(16'({sel.rd_n, sel.wr_n, data_oe, req_ready}), 16'h000E);
    rstn = 1'b1;
    run(rows[1]);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- tb/card_model.sv ----
// Purpose: Card on the far side of the host port
// Assumes: Level view of pins, no clock
// Notes: Writes store whole words; no byte writes
`timescale 1ns/1ns
`default_nettype none
module card_model
  import card_host_pkg::*;
(
  input wire card_sel_s sel,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe,
  input wire logic strap_n_o,
  input wire logic strap_n_oe,
  input wire logic seated,
  output logic [DATA_W-1:0] data_i,
  output logic det_a_n,
  output logic det_b_n,
  output logic is_slave
);
  logic [DATA_W-1:0] mem [0:15] = '{default: 16'h0000};
  logic ide, ce, drv;
  logic [3:0] ix;
  logic [DATA_W-1:0] w, bo;
  // Select and A[2:0] pick an IDE register
  assign ide = !(sel.taskfile_select_n && sel.control_block_select_n);
  assign ce = !(sel.card_enable_low_n && sel.card_enable_high_n);
  assign ix = ide ? {!sel.control_block_select_n, sel.addr[2:0]} : {1'b0, sel.addr[3:1]};
  assign w = mem[ix];
  // Odd byte to low lane on A0 byte read
  assign bo = (!ide && sel.card_enable_high_n && sel.addr[0]) ? {w[15:8], w[15:8]} : w;
  // Drive only under read strobe; floating lines show inverse
  assign drv = !sel.rd_n && (ide || ce);
  assign data_i = drv ? bo : (!data_oe ? data_o : ~w);
  // Level capture avoids racing the release edge
  always @* begin
    if (!sel.wr_n && (ide || ce)) begin
      mem[ix] = data_o;
    end
  end
  assign det_a_n = !seated;
  assign det_b_n = !seated;
  // Pull-up gives slave; mode not looked at
  assign is_slave = strap_n_oe ? 1'b1 : strap_n_o;
endmodule
`default_nettype wire
